//--- verilog/fe_pcs_rx_defs.svh
// constants of the 100 Mb/s receive coding path
`ifndef FE_PCS_RX_DEFS_SVH
`define FE_PCS_RX_DEFS_SVH

// ==========================================================
// code groups
`define CODE_J 5'h18
`define CODE_K 5'h11
`define CODE_T 5'h0D
`define CODE_R 5'h07
`define CODE_IDLE 5'h1F
`define CODE_HALT 5'h04
`define PREAMBLE_NIBBLE 4'h5

// ==========================================================
// timing
`define REF_CLK_PERIOD_PS 5000
`define QUIET_TIME_NS 1000
`define QUIET_CYCLES ((`QUIET_TIME_NS * 1000 + `REF_CLK_PERIOD_PS - 1) / `REF_CLK_PERIOD_PS)
`define LOCK_BITS 30
`define MAX_IDLE_ZERO_RUN 3

`endif

//--- verilog/fe_pcs_rx_pkg.sv
// types of the 100 Mb/s receive coding path
package fe_pcs_rx_pkg;

    typedef enum logic [2:0] {
        SYM_DATA,
        SYM_IDLE,
        SYM_J,
        SYM_K,
        SYM_T,
        SYM_R,
        SYM_ERROR,
        SYM_INVALID
    } sym_class_e;

    typedef struct packed {
        sym_class_e cls;
        logic [3:0] nib;
    } decoded_s;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_REDUCED,
        PWR_DOWN
    } pwr_state_e;

endpackage : fe_pcs_rx_pkg

//--- verilog/fast_ethernet_pcs_receive.sv
// receive coding path: nrzi decode, descramble, align, 5b/4b decode, crs/col, power modes
//
// Function
// - line bits at 125 Mb/s become 4-bit nibbles toward the MII
// - recovered 125 MHz clock and its synchronised data feed the nrzi decoder
// - nrzi coding is undone into nrz before parallelising
// - nrz bits are gathered into parallel words for the descrambler
// - descrambler removes scrambling and passes unaligned 5-bit data on
// - hunt for J then K, then fix the code group boundary
// - aligned data code groups map to nibbles by the standard table
// - J/K removed, two 0101 preamble nibbles sent instead
// - T then R recognised as the last two code groups of a frame
// - T/R stripped, no nibble from them reaches the MAC
// - 11111 is idle and carries no nibble
// - half duplex: collision when transmit and receive are both active
// - collision is shown to the MAC on the collision output
// - full duplex: collision never asserts
// - half duplex: carrier sense while transmitting or receiving
// - full duplex: carrier sense only while receiving
// - no media signal: enter power reduced by itself, link pulses keep going
// - link pulses or line activity wake the device from power reduced
// - auto reduce enable low keeps the device in normal operation
// - power down disables transmit, receive and MII; management stays alive
// - far end frames with J/K replacing preamble and T/R then idles
`timescale 1ns/1ps
`include "fe_pcs_rx_defs.svh"

module fast_ethernet_pcs_receive
    import fe_pcs_rx_pkg::*;
#(
    parameter int QUIET_CYCLES = `QUIET_CYCLES,
    parameter int LOCK_BITS = `LOCK_BITS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic lineClk,
    input wire logic lineNrzi,
    input wire logic mediaSignal,
    input wire logic wakeActivity,
    input wire logic fullDuplex,
    input wire logic txActive,
    input wire logic autoReduceEnable,
    input wire logic powerDown,
    output logic [3:0] rxData,
    output logic rxDataValid,
    output logic rxError,
    output logic rxStrobe,
    output logic carrierSense,
    output logic collision,
    output logic powerReduced,
    output logic poweredDown,
    output logic linkPulseEnable,
    output logic descramblerLocked
);

    localparam int QW = $clog2(QUIET_CYCLES + 1);
    localparam int LW = $clog2(LOCK_BITS + 1);

    // ==========================================================
    // code group lookup
    function automatic decoded_s decodeGroup(input logic [4:0] code);
        decoded_s d;
        d.nib = 4'h0;
        d.cls = SYM_DATA;
        case (code)
            5'h1E: d.nib = 4'h0;
            5'h09: d.nib = 4'h1;
            5'h14: d.nib = 4'h2;
            5'h15: d.nib = 4'h3;
            5'h0A: d.nib = 4'h4;
            5'h0B: d.nib = 4'h5;
            5'h0E: d.nib = 4'h6;
            5'h0F: d.nib = 4'h7;
            5'h12: d.nib = 4'h8;
            5'h13: d.nib = 4'h9;
            5'h16: d.nib = 4'hA;
            5'h17: d.nib = 4'hB;
            5'h1A: d.nib = 4'hC;
            5'h1B: d.nib = 4'hD;
            5'h1C: d.nib = 4'hE;
            5'h1D: d.nib = 4'hF;
            `CODE_IDLE: d.cls = SYM_IDLE;
            `CODE_J: d.cls = SYM_J;
            `CODE_K: d.cls = SYM_K;
            `CODE_T: d.cls = SYM_T;
            `CODE_R: d.cls = SYM_R;
            `CODE_HALT: d.cls = SYM_ERROR;
            default: d.cls = SYM_INVALID;
        endcase
        return d;
    endfunction : decodeGroup

    // ==========================================================
    // reference domain: pin synchronisers
    logic mediaMeta;
    logic mediaSync;
    logic wakeMeta;
    logic wakeSync;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mediaMeta <= 1'b0;
            mediaSync <= 1'b0;
            wakeMeta <= 1'b0;
            wakeSync <= 1'b0;
        end else begin
            mediaMeta <= mediaSignal;
            mediaSync <= mediaMeta;
            wakeMeta <= wakeActivity;
            wakeSync <= wakeMeta;
        end
    end

    // ==========================================================
    // reference domain: power modes
    pwr_state_e pwrState;
    pwr_state_e next_pwrState;
    logic [QW-1:0] quietCnt;
    logic [QW-1:0] next_quietCnt;
    logic quietDone;
    logic wakeRequest;

    assign quietDone = (quietCnt == QW'(QUIET_CYCLES - 1)) && !mediaSync;
    assign wakeRequest = wakeSync || mediaSync || !autoReduceEnable;
    assign next_quietCnt = (pwrState != PWR_NORMAL || mediaSync) ? '0 :
                           (quietDone ? quietCnt : quietCnt + QW'(1));

    always_comb begin
        next_pwrState = pwrState;
        case (pwrState)
            PWR_NORMAL: begin
                if (autoReduceEnable && quietDone) begin
                    next_pwrState = PWR_REDUCED;
                end
            end
            PWR_REDUCED: begin
                if (wakeRequest) begin
                    next_pwrState = PWR_NORMAL;
                end
            end
            PWR_DOWN: begin
                next_pwrState = PWR_NORMAL;
            end
            default: next_pwrState = PWR_NORMAL;
        endcase
        if (powerDown) begin
            next_pwrState = PWR_DOWN;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pwrState <= PWR_NORMAL;
            quietCnt <= '0;
            powerReduced <= 1'b0;
            poweredDown <= 1'b0;
            linkPulseEnable <= 1'b1;
        end else begin
            pwrState <= next_pwrState;
            quietCnt <= next_quietCnt;
            powerReduced <= (next_pwrState == PWR_REDUCED);
            poweredDown <= (next_pwrState == PWR_DOWN);
            linkPulseEnable <= (next_pwrState != PWR_DOWN);
        end
    end

    logic rxEnable;
    assign rxEnable = (pwrState == PWR_NORMAL);

    // ==========================================================
    // link domain: reset release and enable crossing
    logic lineRstMeta;
    logic lineRst;
    logic rxEnMeta;
    logic rxEnLine;

    always_ff @(posedge lineClk or posedge reset) begin
        if (reset) begin
            lineRstMeta <= 1'b1;
            lineRst <= 1'b1;
            rxEnMeta <= 1'b0;
            rxEnLine <= 1'b0;
        end else begin
            lineRstMeta <= 1'b0;
            lineRst <= lineRstMeta;
            rxEnMeta <= rxEnable;
            rxEnLine <= rxEnMeta;
        end
    end

    // ==========================================================
    // link domain: nrzi decode, parallel word, descrambler
    logic nrziPrev;
    logic nrzBit;
    logic [4:0] nrzWord;
    logic [10:0] lfsr;
    logic [LW-1:0] matchCnt;
    logic locked;
    logic inFrame;
    logic [2:0] zeroRun;
    logic keyBit;
    logic plainBit;
    logic [10:0] next_lfsr;
    logic keyMatch;
    logic lockLost;

    assign nrzBit = lineNrzi ^ nrziPrev;
    assign keyBit = lfsr[10] ^ lfsr[8];
    assign plainBit = nrzWord[0] ^ keyBit;
    // idle is all ones, so before lock the key is the inverted line bit
    assign keyMatch = (~nrzWord[0] == keyBit);
    assign next_lfsr = locked ? {lfsr[9:0], keyBit} : {lfsr[9:0], ~nrzWord[0]};
    assign lockLost = locked && !inFrame && !plainBit &&
                      (zeroRun == 3'(`MAX_IDLE_ZERO_RUN));

    // ==========================================================
    // link domain: alignment and decode
    logic [9:0] plainShift;
    logic [9:0] next_plainShift;
    logic [2:0] bitCnt;
    logic sawT;
    logic jkSeen;
    logic groupDone;
    decoded_s grp;
    logic grpBad;
    logic [3:0] heldNib;
    logic heldErr;
    logic [3:0] outNib;
    logic outDv;
    logic outErr;
    logic outToggle;

    assign next_plainShift = {plainShift[8:0], plainBit};
    assign jkSeen = locked && !inFrame && (next_plainShift == {`CODE_J, `CODE_K});
    assign groupDone = inFrame && (bitCnt == 3'd4);
    assign grp = decodeGroup(next_plainShift[4:0]);
    assign grpBad = (grp.cls != SYM_DATA);

    always_ff @(posedge lineClk or posedge lineRst) begin
        if (lineRst) begin
            nrziPrev <= 1'b0;
            nrzWord <= '0;
        end else begin
            nrziPrev <= lineNrzi;
            nrzWord <= {nrzWord[3:0], nrzBit};
        end
    end

    always_ff @(posedge lineClk or posedge lineRst) begin
        if (lineRst) begin
            lfsr <= '0;
            matchCnt <= '0;
            locked <= 1'b0;
            zeroRun <= '0;
        end else if (!rxEnLine || lockLost) begin
            lfsr <= '0;
            matchCnt <= '0;
            locked <= 1'b0;
            zeroRun <= '0;
        end else begin
            lfsr <= next_lfsr;
            zeroRun <= plainBit ? 3'd0 : zeroRun + 3'd1;
            if (!locked) begin
                matchCnt <= keyMatch ? matchCnt + LW'(1) : '0;
                locked <= keyMatch && (matchCnt == LW'(LOCK_BITS - 1));
            end
        end
    end

    always_ff @(posedge lineClk or posedge lineRst) begin
        if (lineRst) begin
            plainShift <= '0;
            bitCnt <= '0;
            inFrame <= 1'b0;
            sawT <= 1'b0;
            heldNib <= '0;
            heldErr <= 1'b0;
            outNib <= '0;
            outDv <= 1'b0;
            outErr <= 1'b0;
            outToggle <= 1'b0;
        end else if (!rxEnLine || !locked) begin
            plainShift <= '0;
            bitCnt <= '0;
            inFrame <= 1'b0;
            sawT <= 1'b0;
            if (outDv) begin
                outDv <= 1'b0;
                outErr <= 1'b0;
                outToggle <= ~outToggle;
            end
        end else begin
            plainShift <= next_plainShift;
            bitCnt <= (jkSeen || groupDone) ? 3'd0 : bitCnt + 3'd1;
            if (jkSeen) begin
                // J slot and K slot each become one preamble nibble
                inFrame <= 1'b1;
                outNib <= `PREAMBLE_NIBBLE;
                outDv <= 1'b1;
                outErr <= 1'b0;
                outToggle <= ~outToggle;
                heldNib <= `PREAMBLE_NIBBLE;
                heldErr <= 1'b0;
            end else if (groupDone) begin
                outToggle <= ~outToggle;
                if (sawT) begin
                    // R closes the frame; anything else flags the end word
                    inFrame <= 1'b0;
                    sawT <= 1'b0;
                    outDv <= 1'b0;
                    outErr <= (grp.cls != SYM_R);
                    outNib <= '0;
                end else if (grp.cls == SYM_T || grp.cls == SYM_IDLE) begin
                    // last held nibble goes out, the delimiter itself never does
                    sawT <= 1'b1;
                    outNib <= heldNib;
                    outDv <= 1'b1;
                    outErr <= heldErr || (grp.cls == SYM_IDLE);
                end else begin
                    outNib <= heldNib;
                    outDv <= 1'b1;
                    outErr <= heldErr;
                    heldNib <= grp.nib;
                    heldErr <= grpBad;
                end
            end
        end
    end

    // ==========================================================
    // reference domain: nibble word crossing
    // the word stands for five link clocks after each toggle, longer than the sync delay
    logic toggleMeta;
    logic toggleSync;
    logic toggleSeen;
    logic lockMeta;
    logic newWord;

    assign newWord = (toggleSync != toggleSeen);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            toggleMeta <= 1'b0;
            toggleSync <= 1'b0;
            toggleSeen <= 1'b0;
            lockMeta <= 1'b0;
            descramblerLocked <= 1'b0;
        end else begin
            toggleMeta <= outToggle;
            toggleSync <= toggleMeta;
            toggleSeen <= toggleSync;
            lockMeta <= locked;
            descramblerLocked <= lockMeta;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rxData <= '0;
            rxDataValid <= 1'b0;
            rxError <= 1'b0;
            rxStrobe <= 1'b0;
        end else if (!rxEnable) begin
            rxData <= '0;
            rxDataValid <= 1'b0;
            rxError <= 1'b0;
            rxStrobe <= 1'b0;
        end else begin
            rxStrobe <= newWord && outDv;
            if (newWord) begin
                rxData <= outNib;
                rxDataValid <= outDv;
                rxError <= outErr;
            end
        end
    end

    // ==========================================================
    // reference domain: carrier sense and collision
    logic next_crs;
    logic next_col;

    assign next_crs = rxEnable && (rxDataValid || (!fullDuplex && txActive));
    assign next_col = rxEnable && !fullDuplex && txActive && rxDataValid;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            carrierSense <= 1'b0;
            collision <= 1'b0;
        end else begin
            carrierSense <= next_crs;
            collision <= next_col;
        end
    end

endmodule : fast_ethernet_pcs_receive

//--- dv/fast_ethernet_pcs_receive_monitor.sv
// assertion checker for the receive coding path
`timescale 1ns/1ps
module fast_ethernet_pcs_receive_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic mediaSignal,
    input wire logic fullDuplex,
    input wire logic txActive,
    input wire logic autoReduceEnable,
    input wire logic powerDown,
    input wire logic rxDataValid,
    input wire logic rxStrobe,
    input wire logic carrierSense,
    input wire logic collision,
    input wire logic powerReduced,
    input wire logic poweredDown,
    input wire logic linkPulseEnable
);
    // ==========================================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic normal;
    assign normal = !powerReduced && !poweredDown;

    property p_col_cause;
        collision |-> $past(!fullDuplex && txActive && rxDataValid);
    endproperty
    a_col_cause: assert property (p_col_cause) else $error("collision without cause");
    property p_crs_cause;
        carrierSense |-> $past(rxDataValid || (!fullDuplex && txActive));
    endproperty
    a_crs_cause: assert property (p_crs_cause) else $error("carrier without cause");
    property p_crs_tx;
        $past(!fullDuplex && txActive) && $past(!reset) && normal && $past(normal)
            && $past(normal, 2) |-> carrierSense;
    endproperty
    a_crs_tx: assert property (p_crs_tx) else $error("carrier missing on transmit");
    property p_strobe;
        rxStrobe |=> !rxStrobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");
    property p_strobe_dv;
        rxStrobe |-> rxDataValid;
    endproperty
    a_strobe_dv: assert property (p_strobe_dv) else $error("strobe outside frame");
    property p_pd_enter;
        $rose(powerDown) |-> ##[1:3] poweredDown;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("power down not entered");
    property p_pd_quiet;
        poweredDown && $past(poweredDown) && $past(poweredDown, 2)
            |-> !linkPulseEnable && !rxDataValid && !carrierSense && !collision;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("activity in power down");
    property p_reduced;
        powerReduced && $past(powerReduced) && $past(powerReduced, 2)
            |-> linkPulseEnable && !rxDataValid && !carrierSense;
    endproperty
    a_reduced: assert property (p_reduced) else $error("wrong outputs when reduced");
    property p_red_entry;
        $rose(powerReduced) |-> $past(autoReduceEnable) && $past(!mediaSignal, 3);
    endproperty
    a_red_entry: assert property (p_red_entry) else $error("reduced entered early");
    property p_auto_off;
        !autoReduceEnable && $past(!autoReduceEnable) && $past(!autoReduceEnable, 2)
            && $past(!autoReduceEnable, 3) |-> !powerReduced;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("reduced while disabled");
endmodule : fast_ethernet_pcs_receive_monitor

bind fast_ethernet_pcs_receive fast_ethernet_pcs_receive_monitor i_fast_ethernet_pcs_receive_monitor (
    .ref_clk(ref_clk), .reset(reset), .mediaSignal(mediaSignal), .fullDuplex(fullDuplex),
    .txActive(txActive), .autoReduceEnable(autoReduceEnable), .powerDown(powerDown),
    .rxDataValid(rxDataValid), .rxStrobe(rxStrobe), .carrierSense(carrierSense),
    .collision(collision), .powerReduced(powerReduced), .poweredDown(poweredDown),
    .linkPulseEnable(linkPulseEnable));

//--- dv/line_tx_model.sv
// far end line transmitter: scrambles code groups and sends them nrzi coded
`timescale 1ns/1ps
module line_tx_model (
    output logic lineClk,
    output logic lineNrzi
);
    // ==========================================================
    // serial stream, idles whenever nothing is queued
    logic [4:0] q[$];
    logic [4:0] cur = 5'h1F;
    logic [10:0] lfsr = 11'h5A3;
    logic nrz;
    int idx = 0;
    initial begin
        lineClk = 1'b0;
        lineNrzi = 1'b0;
        #37;
        forever #80 lineClk = ~lineClk;
    end
    always @(negedge lineClk) begin
        if (idx == 0) begin
            cur = (q.size() > 0) ? q.pop_front() : 5'h1F;
        end
        nrz = cur[4 - idx] ^ (lfsr[10] ^ lfsr[8]);
        lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
        if (nrz) lineNrzi <= ~lineNrzi;
        idx = (idx == 4) ? 0 : idx + 1;
    end
endmodule : line_tx_model

//--- dv/testbench.sv
// self-checking testbench of the receive coding path
`timescale 1ns/1ps
`include "fe_pcs_rx_defs.svh"
module testbench;
    logic ref_clk = 1'b0;
    logic reset, mediaSignal, wakeActivity, fullDuplex, txActive, autoReduceEnable, powerDown;
    logic lineClk, lineNrzi, rxDataValid, rxError, rxStrobe, carrierSense, collision;
    logic powerReduced, poweredDown, linkPulseEnable, descramblerLocked, sawCol;
    logic [3:0] rxData;
    logic [3:0] gotNib[$];
    logic gotErr[$];
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam logic [4:0] CODE5 [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    always #2.5 ref_clk = ~ref_clk;

    line_tx_model i_line_tx_model (.lineClk(lineClk), .lineNrzi(lineNrzi));
    fast_ethernet_pcs_receive #(.QUIET_CYCLES(20), .LOCK_BITS(12)) i_fast_ethernet_pcs_receive (
        .ref_clk(ref_clk), .reset(reset), .lineClk(lineClk), .lineNrzi(lineNrzi),
        .mediaSignal(mediaSignal), .wakeActivity(wakeActivity), .fullDuplex(fullDuplex),
        .txActive(txActive), .autoReduceEnable(autoReduceEnable), .powerDown(powerDown),
        .rxData(rxData), .rxDataValid(rxDataValid), .rxError(rxError), .rxStrobe(rxStrobe),
        .carrierSense(carrierSense), .collision(collision), .powerReduced(powerReduced),
        .poweredDown(poweredDown), .linkPulseEnable(linkPulseEnable),
        .descramblerLocked(descramblerLocked));

    // ==========================================================
    // capture, timeout and report
    always @(negedge ref_clk) begin
        cycles++;
        if (rxStrobe === 1'b1) begin
            gotNib.push_back(rxData);
            gotErr.push_back(rxError);
        end
        if (collision === 1'b1) sawCol = 1'b1;
        if (cycles == 60000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // ==========================================================
    // frame helpers
    task automatic send_frame(input logic [4:0] g[$], input logic txMid);
        int i;
        gotNib.delete();
        gotErr.delete();
        sawCol = 1'b0;
        i_line_tx_model.q.push_back(`CODE_J);
        i_line_tx_model.q.push_back(`CODE_K);
        foreach (g[k]) i_line_tx_model.q.push_back(g[k]);
        i_line_tx_model.q.push_back(`CODE_T);
        i_line_tx_model.q.push_back(`CODE_R);
        for (i = 0; i < 4000 && rxDataValid !== 1'b1; i++) @(negedge ref_clk);
        txActive = txMid;
        for (i = 0; i < 8000 && rxDataValid !== 1'b0; i++) @(negedge ref_clk);
        txActive = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : send_frame

    task automatic cmp_rx(input logic [3:0] en[$], input logic ee[$]);
        check("nibbleCount", 8'(en.size()), 8'(gotNib.size()));
        foreach (en[k]) begin
            if (k < gotNib.size()) begin
                check("rxData", 8'(en[k]), 8'(gotNib[k]));
                check("rxError", 8'(ee[k]), 8'(gotErr[k]));
            end
        end
    endtask : cmp_rx

    // ==========================================================
    // scenarios
    task automatic t_reset();
        check("rxDataValid", 8'h00, 8'(rxDataValid));
        check("linkPulseEnable", 8'h01, 8'(linkPulseEnable));
        check("powerReduced", 8'h00, 8'(powerReduced));
        $display("test reset done");
    endtask : t_reset

    task automatic t_lock();
        int i;
        for (i = 0; i < 3000 && descramblerLocked !== 1'b1; i++) @(negedge ref_clk);
        check("descramblerLocked", 8'h01, 8'(descramblerLocked));
        $display("test lock done");
    endtask : t_lock

    task automatic t_crs();
        fullDuplex = 1'b0;
        txActive = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("carrierSense", 8'h01, 8'(carrierSense));
        check("collision", 8'h00, 8'(collision));
        fullDuplex = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("carrierSense", 8'h00, 8'(carrierSense));
        txActive = 1'b0;
        fullDuplex = 1'b0;
        $display("test carrier done");
    endtask : t_crs

    task automatic t_data();
        logic [4:0] g[$];
        logic [3:0] en[$];
        logic ee[$];
        en = '{4'h5, 4'h5};
        ee = '{1'b0, 1'b0};
        for (int n = 0; n < 16; n++) begin
            g.push_back(CODE5[n]);
            en.push_back(4'(n));
            ee.push_back(1'b0);
        end
        send_frame(g, 1'b1);
        cmp_rx(en, ee);
        check("sawCol", 8'h01, 8'(sawCol));
        $display("test data frame done");
    endtask : t_data

    task automatic t_err();
        fullDuplex = 1'b1;
        send_frame('{5'h09, `CODE_HALT, 5'h00, 5'h19}, 1'b1);
        cmp_rx('{4'h5, 4'h5, 4'h1, 4'h0, 4'h0, 4'h0},
            '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1});
        check("sawCol", 8'h00, 8'(sawCol));
        send_frame('{5'h09, `CODE_IDLE}, 1'b0);
        cmp_rx('{4'h5, 4'h5, 4'h1}, '{1'b0, 1'b0, 1'b1});
        fullDuplex = 1'b0;
        $display("test error frame done");
    endtask : t_err

    task automatic t_power();
        int i;
        mediaSignal = 1'b0;
        for (i = 0; i < 100 && powerReduced !== 1'b1; i++) @(negedge ref_clk);
        check("powerReduced", 8'h01, 8'(powerReduced));
        check("linkPulseEnable", 8'h01, 8'(linkPulseEnable));
        wakeActivity = 1'b1;
        repeat (4) @(negedge ref_clk);
        wakeActivity = 1'b0;
        for (i = 0; i < 20 && powerReduced !== 1'b0; i++) @(negedge ref_clk);
        check("powerReduced", 8'h00, 8'(powerReduced));
        for (i = 0; i < 100 && powerReduced !== 1'b1; i++) @(negedge ref_clk);
        check("powerReduced", 8'h01, 8'(powerReduced));
        autoReduceEnable = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("powerReduced", 8'h00, 8'(powerReduced));
        repeat (60) @(negedge ref_clk);
        check("powerReduced", 8'h00, 8'(powerReduced));
        powerDown = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("poweredDown", 8'h01, 8'(poweredDown));
        check("linkPulseEnable", 8'h00, 8'(linkPulseEnable));
        powerDown = 1'b0;
        mediaSignal = 1'b1;
        autoReduceEnable = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("poweredDown", 8'h00, 8'(poweredDown));
        $display("test power done");
    endtask : t_power

    initial begin
        reset = 1'b1;
        mediaSignal = 1'b1;
        wakeActivity = 1'b0;
        fullDuplex = 1'b0;
        txActive = 1'b0;
        autoReduceEnable = 1'b1;
        powerDown = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_reset();
        reset = 1'b0;
        t_lock();
        t_crs();
        t_data();
        t_err();
        t_power();
        final_report();
    end
endmodule : testbench
